// [hdl/clk_fail_defines.svh]
// constants of the clock-loss watchdog block
// Summary of operation
// - multiplier zero: bypass, divided oscillator drives cpu
// - bypass loss: switch to pll, status, reset
// - multiplier nonzero: pll times n drives cpu
// - pll loss: status, reset, half limp rate
// - standby loss: status, reset, limp by divider
// - detection waits for halt-exit power-up
// - post-halt overflow: status, reset, limp routing
// - immediate reset unless fail path selected
// - fail path: flag raises nmi, starts watchdog
// - uncleared watchdog expiry forces missing-clock reset
// - watchdog reset stays internal, no pin
// - clock-fail flag drives trip zone five
// - emulation stop drives trip zone six
// - watchdog runs on system clock
// - writes need protected write enable
// - config enable set-only, reset clears
// - fail flag latches, cleared by clear/reset
// - nmi flag records, blocks further nmis
// - clear register write-one clears, set wins
// - force register bit sets fail flag
// - counter counts while enabled flag set, holds during emulation stop
// - period resets max; equal write fires
`ifndef CLK_FAIL_DEFINES_SVH
`define CLK_FAIL_DEFINES_SVH
`define IDX_CFG    30'h00007060
`define IDX_FLG    30'h00007061
`define IDX_CLR    30'h00007062
`define IDX_FRC    30'h00007063
`define IDX_CNT    30'h00007064
`define IDX_PRD    30'h00007065
`define IDX_CTRL   30'h00007066
`define IDX_MULT   30'h00007067
`define IDX_STS    30'h00007068
`define BIT_CF     1
`define BIT_NMI    0
`define BIT_FPS    2
`define BIT_MCS    0
`define BIT_MCLR   1
`define DIV_LSB    0
`define DIV_MSB    1
`define PRD_RESET  16'hFFFF
`define MULT_BYP   16'h0000
`define DIV_FULL   2'h3
`define DIV_HALF   2'h2
`define DIV_QUART  2'h0
`endif

// [hdl/clk_fail_pkg.sv]
// types of the clock-loss watchdog block
package clk_fail_pkg;
    typedef enum logic [0:0] {ST_NORMAL, ST_LIMP} clk_state_t;
endpackage : clk_fail_pkg

// [hdl/wd_if.sv]
// link between the register side and the fail watchdog counter
`timescale 1ns/10ps
`default_nettype none
interface wd_if;
    logic        active;
    logic        hold;
    logic [15:0] period;
    logic [15:0] count;
    logic        fire;
    modport ctrl (output active, hold, period, input count, fire);
    modport wd   (input active, hold, period, output count, fire);
endinterface : wd_if
`default_nettype wire

// [hdl/bit_sync.sv]
// two-stage synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module bit_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic din,
    output var  logic dout
);
    logic [1:0] s_q;
    logic [1:0] s_d;

    // first stage feeds only the second
    always_comb begin
        s_d = {s_q[0], din};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q[1];
endmodule : bit_sync
`default_nettype wire

// [hdl/osc_loss_watchdog.sv]
// fail watchdog counter, runs on the system clock
`timescale 1ns/10ps
`default_nettype none
module osc_loss_watchdog (
    input wire logic clk,
    input wire logic arst_n,
    wd_if.wd         w
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        fire_q;
    logic        fire_d;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ************************************************
    // counter
    // ************************************************
    // a smaller period simply wraps through zero first
    always_comb begin
        cnt_d  = cnt_q;
        fire_d = 1'b0;
        if (!w.active) begin
            cnt_d = 16'h0000;
        end else if (w.hold) begin
            cnt_d = cnt_q;
        end else if (cnt_q == w.period) begin
            cnt_d  = 16'h0000;
            fire_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    // clocked by the system clock that limp mode keeps alive
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= 16'h0000;
            fire_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            fire_q <= fire_d;
        end
    end

    assign w.count = cnt_q;
    assign w.fire  = fire_q;

    a_wd_match_fire: assert property (
        w.active && !w.hold && cnt_q == w.period
        |=> fire_q && cnt_q == 16'h0000)
        else $error("watchdog did not fire on period match");
    a_wd_idle_zero: assert property (
        !w.active |=> cnt_q == 16'h0000 && !fire_q)
        else $error("watchdog counted without enabled flag");
endmodule : osc_loss_watchdog
`default_nettype wire

// [hdl/clock_loss_nmi_watchdog.sv]
// clock-loss handling with clock-fail interrupt and watchdog
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "clk_fail_defines.svh"
module clock_loss_nmi_watchdog
    import clk_fail_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        protected_write_enable,
    input  wire logic        osc_missing,
    input  wire logic        standby_mode,
    input  wire logic        halt_mode,
    input  wire logic        osc_pll_powered,
    input  wire logic        emulation_stop_out,
    output var  logic        cpu_clk_from_pll,
    output var  logic [1:0]  cpu_clk_div,
    output var  logic        cpu_clk_stopped,
    output var  logic        pll_enable,
    output var  logic        missing_clock_status,
    output var  logic        missing_clock_reset,
    output var  logic        osc_loss_wd_reset,
    output var  logic        nmi_out,
    output var  logic        trip_zone_five,
    output var  logic        trip_zone_six
);
    // ************************************************
    // declarations
    // ************************************************
    logic        osc_miss_s;
    logic        fail_lvl;
    logic        fail_lvl_q;
    logic        fail_evt;
    logic        setup;
    logic        wr;
    logic        wr_ok;
    logic [29:0] idx;
    logic        cfg_en_q, cfg_en_d;
    logic        cf_q, cf_d;
    logic        nmif_q, nmif_d;
    logic [15:0] prd_q, prd_d;
    logic        fps_q, fps_d;
    logic [1:0]  divider_select_q, divider_select_d;
    logic [15:0] mult_q, mult_d;
    logic        mcs_q, mcs_d;
    logic        nmi_set;
    logic        cf_set;
    clk_state_t  st_q, st_d;
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;
    logic        src_d;
    logic [1:0]  div_d;
    logic        mrst_d;
    logic        nmi_d;
    logic        stop_d;
    logic        tz5_d;
    logic        tz6_d;
    logic        pllen_d;
    logic        wdr_d;

    wd_if wdl ();

    // ************************************************
    // helpers
    // ************************************************
    // recognised register indices, used by the error decode only
    function automatic logic mapped(input logic [29:0] i);
        mapped = (i >= `IDX_CFG) && (i <= `IDX_STS);
    endfunction : mapped

    // divide code while in limp; pll mode is half rate outside standby and halt
    function automatic logic [1:0] limp_div(
        input logic       byp,
        input logic       lowpwr,
        input logic [1:0] dsel
    );
        if (!byp && !lowpwr) begin
            limp_div = `DIV_HALF;
        end else if (lowpwr) begin
            limp_div = dsel;
        end else if (dsel == `DIV_FULL) begin
            limp_div = `DIV_FULL;
        end else begin
            limp_div = `DIV_HALF;
        end
    endfunction : limp_div

    // ************************************************
    // detection
    // ************************************************
    bit_sync u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (osc_missing),
        .dout   (osc_miss_s)
    );

    // counters stay blind through halt and until power-up ends
    assign fail_lvl = osc_miss_s && !halt_mode && osc_pll_powered;
    assign fail_evt = fail_lvl && !fail_lvl_q;

    // ************************************************
    // bus decode
    // ************************************************
    assign idx   = paddr[31:2];
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite && pready;
    // every register write needs protected_write_enable; the counter is not writable
    assign wr_ok = wr && protected_write_enable;

    // ************************************************
    // register and flag next values
    // ************************************************
    // hardware sets are applied last so they win over clears
    always_comb begin
        cfg_en_d = cfg_en_q;
        cf_d     = cf_q;
        nmif_d   = nmif_q;
        prd_d    = prd_q;
        fps_d    = fps_q;
        divider_select_d = divider_select_q;
        mult_d   = mult_q;
        mcs_d    = mcs_q;
        cf_set   = fail_evt;
        if (wr_ok && idx == `IDX_CFG && pwdata[`BIT_CF]) begin
            cfg_en_d = 1'b1;
        end
        if (wr_ok && idx == `IDX_CLR) begin
            if (pwdata[`BIT_CF]) begin
                cf_d = 1'b0;
            end
            if (pwdata[`BIT_NMI]) begin
                nmif_d = 1'b0;
            end
        end
        if (wr_ok && idx == `IDX_FRC && pwdata[`BIT_CF]) begin
            cf_set = 1'b1;
        end
        if (wr_ok && idx == `IDX_PRD) begin
            prd_d = pwdata[15:0];
        end
        if (wr_ok && idx == `IDX_CTRL) begin
            divider_select_d = pwdata[`DIV_MSB:`DIV_LSB];
            fps_d    = pwdata[`BIT_FPS];
        end
        if (wr_ok && idx == `IDX_MULT) begin
            mult_d = pwdata[15:0];
        end
        if (wr_ok && idx == `IDX_STS && pwdata[`BIT_MCLR]) begin
            mcs_d = 1'b0;
        end
        nmi_set = cfg_en_q && cf_q && !nmif_q;
        if (cf_set) begin
            cf_d = 1'b1;
        end
        if (nmi_set) begin
            nmif_d = 1'b1;
        end
        if (fail_evt) begin
            mcs_d = 1'b1;
        end
    end

    // ************************************************
    // clock source state
    // ************************************************
    // limp is left only when software clears the status bit
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_NORMAL: begin
                if (fail_evt) begin
                    st_d = ST_LIMP;
                end
            end
            ST_LIMP: begin
                if (!mcs_d && !fail_lvl) begin
                    st_d = ST_NORMAL;
                end
            end
            default: begin
                st_d = ST_NORMAL;
            end
        endcase
    end

    // ************************************************
    // output next values
    // ************************************************
    always_comb begin
        pllen_d = (mult_q != `MULT_BYP);
        stop_d  = standby_mode || halt_mode;
        // next state steers the source so it moves with the status bit
        if (st_d == ST_LIMP) begin
            src_d = 1'b1;
            div_d = limp_div(mult_q == `MULT_BYP, stop_d, divider_select_q);
        end else begin
            src_d = pllen_d;
            div_d = divider_select_q;
        end
        // watchdog reset feeds the missing-clock reset, never a pin
        wdr_d  = wdl.fire;
        mrst_d = (fail_evt && !fps_q) || wdl.fire;
        nmi_d  = nmi_set;
        tz5_d  = cf_q;
        tz6_d  = emulation_stop_out;
    end

    // watchdog runs while an enabled fail flag stands, held while emulation_stop_out is high
    assign wdl.active = cfg_en_q && cf_q;
    assign wdl.hold   = emulation_stop_out;
    assign wdl.period = prd_q;

    osc_loss_watchdog u_wd (
        .clk    (clk),
        .arst_n (arst_n),
        .w      (wdl)
    );

    // ************************************************
    // bus answer
    // ************************************************
    // answer is prepared in setup so access ends in one cycle
    always_comb begin
        prdata_d  = 32'h00000000;
        pready_d  = setup;
        pslverr_d = setup && !mapped(idx);
        if (setup) begin
            case (idx)
                `IDX_CFG:  prdata_d[`BIT_CF]  = cfg_en_q;
                `IDX_FLG: begin
                    prdata_d[`BIT_CF]  = cf_q;
                    prdata_d[`BIT_NMI] = nmif_q;
                end
                `IDX_CNT:  prdata_d[15:0] = wdl.count;
                `IDX_PRD:  prdata_d[15:0] = prd_q;
                `IDX_CTRL: begin
                    prdata_d[`DIV_MSB:`DIV_LSB] = divider_select_q;
                    prdata_d[`BIT_FPS]          = fps_q;
                end
                `IDX_MULT: prdata_d[15:0] = mult_q;
                `IDX_STS:  prdata_d[`BIT_MCS] = mcs_q;
                default:   prdata_d = 32'h00000000;
            endcase
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fail_lvl_q           <= 1'b0;
            cfg_en_q             <= 1'b0;
            cf_q                 <= 1'b0;
            nmif_q               <= 1'b0;
            prd_q                <= `PRD_RESET;
            fps_q                <= 1'b0;
            divider_select_q             <= `DIV_QUART;
            mult_q               <= `MULT_BYP;
            mcs_q                <= 1'b0;
            st_q                 <= ST_NORMAL;
            prdata               <= 32'h00000000;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
            cpu_clk_from_pll     <= 1'b0;
            cpu_clk_div          <= `DIV_QUART;
            cpu_clk_stopped      <= 1'b0;
            pll_enable           <= 1'b0;
            missing_clock_status <= 1'b0;
            missing_clock_reset  <= 1'b0;
            osc_loss_wd_reset    <= 1'b0;
            nmi_out              <= 1'b0;
            trip_zone_five       <= 1'b0;
            trip_zone_six        <= 1'b0;
        end else begin
            fail_lvl_q           <= fail_lvl;
            cfg_en_q             <= cfg_en_d;
            cf_q                 <= cf_d;
            nmif_q               <= nmif_d;
            prd_q                <= prd_d;
            fps_q                <= fps_d;
            divider_select_q             <= divider_select_d;
            mult_q               <= mult_d;
            mcs_q                <= mcs_d;
            st_q                 <= st_d;
            prdata               <= prdata_d;
            pready               <= pready_d;
            pslverr              <= pslverr_d;
            cpu_clk_from_pll     <= src_d;
            cpu_clk_div          <= div_d;
            cpu_clk_stopped      <= stop_d;
            pll_enable           <= pllen_d;
            missing_clock_status <= mcs_d;
            missing_clock_reset  <= mrst_d;
            osc_loss_wd_reset    <= wdr_d;
            nmi_out              <= nmi_d;
            trip_zone_five       <= tz5_d;
            trip_zone_six        <= tz6_d;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    a_apb_one_wait: assert property (
        s_setup |=> pready && $stable(paddr) or !psel)
        else $error("bus answer not ready in access phase");
    a_immediate_reset: assert property (
        fail_evt && !fps_q |=> missing_clock_reset)
        else $error("missing clock reset not immediate");
    a_delayed_no_reset: assert property (
        fail_evt && fps_q && !wdl.fire |=> !missing_clock_reset)
        else $error("fail path reset came without watchdog");
    a_wd_reset_feeds: assert property (
        wdl.fire |=> osc_loss_wd_reset && missing_clock_reset)
        else $error("watchdog expiry did not reset");
    a_fail_flag_set: assert property (
        fail_evt |=> cf_q ##1 trip_zone_five)
        else $error("clock fail flag or trip not raised");
    a_set_beats_clear: assert property (
        fail_evt && wr_ok && idx == `IDX_CLR && pwdata[`BIT_CF]
        |=> cf_q)
        else $error("clear won over hardware set");
    a_cfg_sticky: assert property (
        cfg_en_q |=> cfg_en_q)
        else $error("interrupt enable was cleared");
    a_nmi_single: assert property (
        nmif_q && $past(nmif_q) |-> !nmi_set ##1 !nmi_out)
        else $error("second interrupt while flag set");
    a_nmi_fires: assert property (
        cfg_en_q && cf_q && !nmif_q |=> nmi_out && nmif_q)
        else $error("enabled clock fail gave no interrupt");
    a_limp_enter: assert property (
        fail_evt |=> cpu_clk_from_pll && missing_clock_status)
        else $error("loss did not switch to limp clock");
    a_bypass_src: assert property (
        st_d == ST_NORMAL && mult_q == `MULT_BYP
        |=> !cpu_clk_from_pll && cpu_clk_div == $past(divider_select_q))
        else $error("bypass did not select oscillator");
    a_halt_blind: assert property (
        halt_mode || !osc_pll_powered |-> !fail_evt)
        else $error("detection active before power-up");
    a_prot_write: assert property (
        s_access ##0 pwrite && !protected_write_enable
        && idx == `IDX_PRD |=> prd_q == $past(prd_q))
        else $error("protected write took effect");
endmodule : clock_loss_nmi_watchdog
`default_nettype wire

// [bench/cpu_nmi_model.sv]
// cpu model that services the clock-fail interrupt
`timescale 1ns/10ps
`default_nettype none
module cpu_nmi_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       nmi_out,
    input  wire logic       slow,
    input  wire logic       ack,
    output var  logic       req,
    output var  logic [7:0] nmi_n
);
    logic [7:0] wait_q;
    // handler entry delay; slow entry misses the watchdog deadline
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req    <= 1'b0;
            nmi_n  <= 8'h00;
            wait_q <= 8'h00;
        end else begin
            if (nmi_out) begin
                nmi_n  <= nmi_n + 8'h01;
                wait_q <= slow ? 8'h30 : 8'h01;
            end else if (wait_q != 8'h00) begin
                wait_q <= wait_q - 8'h01;
            end
            if (wait_q == 8'h01) req <= 1'b1;
            if (ack) req <= 1'b0;
        end
    end
endmodule : cpu_nmi_model
`default_nettype wire

// [bench/tb_clock_loss_nmi_watchdog.sv]
// self-checking bench of the clock-loss watchdog block
`timescale 1ns/10ps
`default_nettype none
`include "clk_fail_defines.svh"
module tb_clock_loss_nmi_watchdog
    import clk_fail_pkg::*;
;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic        protected_write_enable, osc_missing, standby_mode;
    logic        halt_mode, osc_pll_powered, emulation_stop_out;
    logic        cpu_clk_from_pll, cpu_clk_stopped, pll_enable, nmi_out;
    logic [1:0]  cpu_clk_div;
    logic        missing_clock_status, missing_clock_reset;
    logic        osc_loss_wd_reset, trip_zone_five, trip_zone_six;
    logic        slow, ack, req;
    logic [7:0]  nmi_n;
    logic [32:0] exp_q[$];
    int          mismatches, tests_run, mcr_n, wdr_n, seed, p, m0, w0, n0;

    clock_loss_nmi_watchdog dut_u (
        .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .protected_write_enable, .osc_missing,
        .standby_mode, .halt_mode, .osc_pll_powered, .emulation_stop_out,
        .cpu_clk_from_pll, .cpu_clk_div, .cpu_clk_stopped, .pll_enable,
        .missing_clock_status, .missing_clock_reset, .osc_loss_wd_reset,
        .nmi_out, .trip_zone_five, .trip_zone_six
    );
    cpu_nmi_model cpu_u (.clk, .arst_n, .nmi_out, .slow, .ack, .req, .nmi_n);

    // ********
    // monitors
    // ********
    initial clk = 1'b0;
    // system clock, 25 ns period
    always #12.5 clk = ~clk;

    // tallies of the one-cycle internal reset pulses
    always @(posedge clk) begin
        mcr_n += int'(missing_clock_reset === 1'b1);
        wdr_n += int'(osc_loss_wd_reset === 1'b1);
    end

    // each finished read is judged against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() > 0) check("read", exp_q.pop_front(),
                                        {pslverr, prdata});
        end
    end

    // *****
    // tasks
    // *****
    task automatic check(input string nm, input logic [32:0] e,
                         input logic [32:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic check_n(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask : check_n

    // entered just after an edge; request held until pready is seen
    task automatic apb(input logic w, input logic [29:0] i,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the hang guard ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [29:0] i, input logic [31:0] d);
        apb(1'b1, i, d);
    endtask : wr

    task automatic rd(input logic [29:0] i, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, i, 32'h0);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic mark;
        m0 = mcr_n;
        w0 = wdr_n;
        n0 = nmi_n;
    endtask : mark

    // service request: fail flag first, then the interrupt flag
    task automatic serve;
        repeat (100) begin
            if (req === 1'b1) break;
            @(posedge clk);
        end
        wr(`IDX_CLR, 32'h2);
        wr(`IDX_CLR, 32'h1);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
    endtask : serve

    // back to a clean state after a loss
    task automatic recover;
        osc_missing <= 1'b0;
        wr(`IDX_STS, 32'h2);
        wr(`IDX_CLR, 32'h3);
        rd(`IDX_FLG, 33'h0);
    endtask : recover

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #500000;
        mismatches++;
        results();
    end

    // ********
    // sequence
    // ********
    initial begin
        seed = 32'hE2BDA433;
        {arst_n, psel, penable, pwrite, protected_write_enable} = '0;
        {osc_missing, standby_mode, halt_mode, emulation_stop_out} = '0;
        {slow, ack, paddr, pwdata} = '0;
        osc_pll_powered = 1'b1;
        tick(12);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(`IDX_PRD, 33'h0FFFF);
        rd(`IDX_CFG, 33'h0);
        rd(`IDX_FLG, 33'h0);
        rd(30'h00007070, 33'h100000000);
        wr(`IDX_PRD, $random(seed));
        rd(`IDX_PRD, 33'h0FFFF);
        protected_write_enable <= 1'b1;
        wr(`IDX_CNT, 32'h1234);
        rd(`IDX_CNT, 33'h0);
        rd(`IDX_CLR, 33'h0);
        $display("done: reset and access");
        for (int k = 0; k < 4; k++) begin
            wr(`IDX_CTRL, k);
            tick(1);
            check("div", k, cpu_clk_div);
        end
        check("pll", 33'h0, {pll_enable, cpu_clk_from_pll});
        // bypass loss with the immediate reset path
        mark();
        osc_missing <= 1'b1;
        tick(6);
        check_n("mcr", m0 + 1, mcr_n);
        check("limp", 33'hF, {missing_clock_status, cpu_clk_from_pll,
                              cpu_clk_div});
        rd(`IDX_FLG, 33'h2);
        recover();
        wr(`IDX_MULT, 32'h5);
        tick(1);
        check("pll", 33'h3, {pll_enable, cpu_clk_from_pll});
        $display("done: clock modes");
        // loss during halt and power-up is not seen until powered
        mark();
        halt_mode <= 1'b1;
        osc_missing <= 1'b1;
        tick(6);
        halt_mode <= 1'b0;
        osc_pll_powered <= 1'b0;
        tick(6);
        check_n("mcr", m0, mcr_n);
        osc_pll_powered <= 1'b1;
        tick(6);
        check_n("mcr", m0 + 1, mcr_n);
        check("limp", 33'h6, {missing_clock_status, cpu_clk_div});
        standby_mode <= 1'b1;
        tick(2);
        check("stop", 33'h1, cpu_clk_stopped);
        standby_mode <= 1'b0;
        recover();
        $display("done: halt and pll loss");
        // delayed path, prompt handler
        wr(`IDX_CFG, 32'h2);
        wr(`IDX_CFG, 32'h0);
        rd(`IDX_CFG, 33'h2);
        wr(`IDX_CTRL, 32'h7);
        p = 16 + ($random(seed) & 7);
        wr(`IDX_PRD, p);
        rd(`IDX_PRD, p);
        mark();
        wr(`IDX_FRC, 32'h2);
        tick(2);
        check("tz5", 33'h1, trip_zone_five);
        rd(`IDX_FLG, 33'h3);
        serve();
        rd(`IDX_CNT, 33'h0);
        check_n("nmi", n0 + 1, nmi_n);
        check_n("wdr", w0, wdr_n);
        $display("done: prompt handler");
        // delayed path, late handler lets the watchdog expire
        slow <= 1'b1;
        mark();
        osc_missing <= 1'b1;
        tick(6);
        check_n("mcr", m0, mcr_n);
        tick(p + 6);
        check_n("wdr", w0 + 1, wdr_n);
        check_n("mcr", m0 + 1, mcr_n);
        wr(`IDX_FRC, 32'h2);
        check_n("nmi", n0 + 1, nmi_n);
        osc_missing <= 1'b0;
        serve();
        recover();
        $display("done: watchdog expiry");
        emulation_stop_out <= 1'b1;
        tick(2);
        check("tz6", 33'h1, trip_zone_six);
        emulation_stop_out <= 1'b0;
        tick(2);
        check("tz6", 33'h0, trip_zone_six);
        check_n("queue", 0, exp_q.size());
        $display("done: trip inputs");
        results();
    end
endmodule : tb_clock_loss_nmi_watchdog
`default_nettype wire
